/* File: bus_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
module bus_master_model
(
   // Clock.
   input wire logic mclk,
   // Command word towards the drive.
   output logic [15:0] bus_command_word = 16'h0000,
   output logic bus_command_strobe = 1'b0
);
   task automatic put(input logic [15:0] v);
      @(negedge mclk);
      bus_command_word = v;
      bus_command_strobe = 1'b1;
   endtask : put
   // Between telegrams the strobe drops and the word is inverted bit for bit.
   task automatic idle();
      @(negedge mclk);
      bus_command_strobe = 1'b0;
      bus_command_word = ~bus_command_word;
   endtask : idle
endmodule : bus_master_model
`default_nettype wire

/* File: dcsw_props.sv */
`timescale 1ns/100ps
`default_nettype none
module dcsw_props
(
   // Command side.
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [15:0] bus_command_word,
   input wire logic bus_command_strobe,
   // Observed side.
   input wire drive_word_pkg::drive_cond_type drive_cond,
   input wire drive_word_pkg::drive_cmd_type drive_cmd,
   input wire logic trip_reset_pulse,
   input wire logic [15:0] drive_state_word
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire logic [15:0] cw = bus_command_word;
   wire logic take = bus_command_strobe && cw[10];
   property p_pulse; trip_reset_pulse |-> $past(take && cw[7]); endproperty
   a_pulse: assert property (p_pulse) else $error("stray pulse");
   property p_once; trip_reset_pulse |=> !trip_reset_pulse; endproperty
   a_once: assert property (p_once) else $error("double pulse");
   property p_sel; take |-> ##2
      drive_cmd.preset_sel == $past(cw[1:0], 2); endproperty
   a_sel: assert property (p_sel) else $error("preset");
   property p_brake; take |-> ##2
      drive_cmd.dc_brake == !$past(cw[2], 2); endproperty
   a_brake: assert property (p_brake) else $error("brake");
   property p_coast; take |-> ##2 drive_cmd.coast == !$past(cw[3], 2); endproperty
   a_coast: assert property (p_coast) else $error("coast");
   property p_hold; take |-> ##2 drive_cmd.freeze == !$past(cw[5], 2); endproperty
   a_hold: assert property (p_hold) else $error("freeze");
   property p_trip; drive_cond.tripped |=>
      !drive_state_word[0] && drive_state_word[3]; endproperty
   a_trip: assert property (p_trip) else $error("trip bits");
   property p_bus; 1'b1 |=> drive_state_word[9] ==
      !$past(drive_cond.off_key || drive_cond.local_site); endproperty
   a_bus: assert property (p_bus) else $error("bus control");
endmodule : dcsw_props
`default_nettype wire

/* File: drive_control_status_words.sv */
`timescale 1ns/100ps
`default_nettype none
module drive_control_status_words
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Command word from the bus master.
   input wire logic [15:0] bus_command_word,
   input wire logic bus_command_strobe,
   // Drive configuration and present conditions.
   input wire drive_word_pkg::drive_cfg_type drive_cfg,
   input wire drive_word_pkg::drive_cond_type drive_cond,
   input wire logic reverse_input,
   // Decoded commands.
   output drive_word_pkg::drive_cmd_type drive_cmd,
   output logic trip_reset_pulse,
   // Status word back to the master.
   output logic [15:0] drive_state_word
);
   import drive_word_pkg::*;

   logic [15:0] cmd_word_ff;
   logic reset_bit_ff;
   drive_cmd_type cmd_ff;
   logic trip_reset_ff;
   logic [15:0] state_ff;
   drive_cmd_type nxt_cmd;
   logic [15:0] nxt_state;
   logic rev_allowed;
   logic take_word;

   // Words with the valid bit clear are dropped whole.
   assign take_word = bus_command_strobe
      & bus_command_word[CMD_VALID];

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         cmd_word_ff <= CMD_RESET_VAL;
      end
      else if (take_word)
      begin
         cmd_word_ff <= bus_command_word;
      end
   end

   // The reset bit is tracked per accepted word so only a 0-to-1 step acts.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         reset_bit_ff <= 1'b0;
         trip_reset_ff <= 1'b0;
      end
      else
      begin
         trip_reset_ff <= take_word & bus_command_word[CMD_RESET]
            & ~reset_bit_ff;
         if (take_word)
         begin
            reset_bit_ff <= bus_command_word[CMD_RESET];
         end
      end
   end

   assign rev_allowed = (drive_cfg.reverse_src != REV_SRC_INPUT);

   always_comb
   begin
      nxt_cmd.preset_sel = cmd_word_ff[CMD_REF_MSB:CMD_REF_LSB];
      nxt_cmd.dc_brake = ~cmd_word_ff[CMD_RAMP_NOT_BRAKE];
      nxt_cmd.coast = ~cmd_word_ff[CMD_NO_COAST];
      nxt_cmd.freeze = ~cmd_word_ff[CMD_NO_HOLD];
      // While frozen, only coast or brake may stop the motor.
      nxt_cmd.quick_stop = ~cmd_word_ff[CMD_NO_QSTOP]
         & ~nxt_cmd.freeze;
      nxt_cmd.ramp_stop = ~cmd_word_ff[CMD_START]
         & ~nxt_cmd.freeze;
      nxt_cmd.jog = cmd_word_ff[CMD_JOG];
      nxt_cmd.ramp_pair2 = cmd_word_ff[CMD_RAMP2];
      nxt_cmd.relay1 = cmd_word_ff[CMD_RELAY1]
         & (drive_cfg.relay1_func == RELAY1_SEL_CODE);
      nxt_cmd.relay2 = cmd_word_ff[CMD_RELAY2]
         & (drive_cfg.relay2_func == RELAY2_SEL_CODE);
      nxt_cmd.setup2 = cmd_word_ff[CMD_SETUP]
         & drive_cfg.multi_setup;
      // Bit 14 is never read.
      unique case (drive_cfg.reverse_src)
         REV_SRC_BUS: nxt_cmd.reverse = cmd_word_ff[CMD_REVERSE];
         REV_SRC_OR: nxt_cmd.reverse = cmd_word_ff[CMD_REVERSE]
            | reverse_input;
         REV_SRC_AND: nxt_cmd.reverse = cmd_word_ff[CMD_REVERSE]
            & reverse_input;
         REV_SRC_INPUT: nxt_cmd.reverse = reverse_input;
      endcase
      if (!rev_allowed)
      begin
         nxt_cmd.reverse = reverse_input;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         cmd_ff <= '0;
      end
      else
      begin
         cmd_ff <= nxt_cmd;
      end
   end

   always_comb
   begin
      nxt_state = 16'h0000;
      nxt_state[0] = drive_cond.control_ready
         & ~drive_cond.tripped;
      nxt_state[1] = drive_cond.drive_ready;
      nxt_state[2] = ~nxt_cmd.coast & ~drive_cond.tripped;
      nxt_state[3] = drive_cond.tripped;
      nxt_state[4] = drive_cond.error_no_trip;
      nxt_state[6] = drive_cond.trip_locked;
      nxt_state[7] = drive_cond.warning;
      nxt_state[8] = drive_cond.speed_at_ref;
      nxt_state[9] = ~drive_cond.off_key
         & ~drive_cond.local_site;
      nxt_state[10] = drive_cond.freq_in_limits;
      // A frozen word masks the ramp stop, so read the start bit itself.
      nxt_state[11] = (cmd_word_ff[CMD_START] & ~nxt_cmd.coast)
         | drive_cond.output_running;
      nxt_state[12] = drive_cond.overtemp_stop;
      nxt_state[13] = drive_cond.voltage_fault;
      nxt_state[14] = drive_cond.torque_exceeded;
      nxt_state[15] = drive_cond.timer_exceeded;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state_ff <= 16'h0000;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign drive_cmd = cmd_ff;
   assign trip_reset_pulse = trip_reset_ff;
   assign drive_state_word = state_ff;

endmodule : drive_control_status_words
`default_nettype wire

/* File: drive_control_status_words_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module drive_control_status_words_bench;
   import drive_word_pkg::*;
   logic mclk, rst_n, strobe, pulse, reverse_input, s1 = 0, s2 = 0;
   logic [15:0] cw, w, sw;
   drive_cfg_type cfg;
   drive_cond_type cond;
   drive_cmd_type cmd;
   int n_fail = 0, n_checks = 0;
   logic [28:0] qc[$];
   logic qp[$];
   logic [15:0] tbl[7] = '{16'h0400, 16'h0480, 16'h0480, 16'h0000, 16'h0480,
      16'h0400, 16'h0480};
   bus_master_model i_master (.mclk(mclk), .bus_command_word(cw),
      .bus_command_strobe(strobe));
   drive_control_status_words i_dut (.mclk(mclk), .rst_n(rst_n),
      .bus_command_word(cw), .bus_command_strobe(strobe), .drive_cfg(cfg),
      .drive_cond(cond), .reverse_input(reverse_input), .drive_cmd(cmd),
      .trip_reset_pulse(pulse), .drive_state_word(sw));
   function automatic logic [28:0] expect_of(input logic [15:0] v);
      logic [3:0] t;
      t = {v[15] & reverse_input, v[15] | reverse_input, v[15], reverse_input};
      return {v[1:0], !v[2], !v[3], !v[4] & v[5], !v[5], !v[6] & v[5], v[8],
         v[9], v[11] & cfg[18:11] == 8'h24, v[12] & cfg[10:3] == 8'h25,
         v[13] & cfg[2], t[cfg[1:0]], cond[0], cond[1], cond[2], cond[3],
         v[6] & v[3] | cond[4],
         cond[5], !(cond[7] | cond[6]), cond[8], cond[9], cond[10], 1'b0,
         cond[11], cond[12], v[3] & !cond[12], cond[13], cond[14] & !cond[12]};
   endfunction : expect_of
   task automatic check(input string what, input logic [28:0] e, s);
      n_checks++;
      if (s !== e)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, e, s);
      end
   endtask : check
   task automatic send(input logic [15:0] v);
      i_master.put(v);
      qp.push_back(v[10] & v[7] & !w[7]);
      if (v[10])
         w = v;
      qc.push_back(expect_of(w));
   endtask : send
   task automatic drain(input string name);
      i_master.idle();
      repeat (3) @(negedge mclk);
      $display("test done: %s", name);
   endtask : drain
   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   always @(posedge mclk)
   begin
      s1 <= strobe;
      s2 <= s1;
   end
   always @(negedge mclk)
   begin
      if (s1)
         check("pulse", 29'(qp.pop_front()), 29'(pulse));
      if (s2)
         check("cmd_state", qc.pop_front(), {cmd, sw});
   end
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial
   begin
      #1000000;
      n_fail++;
      summarize();
   end
   initial
   begin
      rst_n = 1'b0;
      cfg = '0;
      cond = '0;
      reverse_input = 1'b0;
      w = 16'h0000;
      void'($urandom(74225));
      repeat (12) @(negedge mclk);
      rst_n = 1'b1;
      send(16'hFBFF);
      drain("reset state");
      foreach (tbl[i])
         send(tbl[i]);
      drain("trip reset edges");
      for (int m = 0; m < 8; m++)
      begin
         cfg = drive_cfg_type'(19'($urandom));
         cond = drive_cond_type'(15'($urandom));
         reverse_input = 1'($urandom);
         cfg.reverse_src = 2'(m);
         if (m[2])
            cfg = {8'h24, 8'h25, cfg[2:0]};
         for (int i = 0; i < 300; i++)
            send(16'($urandom));
         drain("random words");
      end
      summarize();
   end
endmodule : drive_control_status_words_bench
bind drive_control_status_words dcsw_props i_props (.mclk(mclk),
   .rst_n(rst_n), .bus_command_word(bus_command_word),
   .bus_command_strobe(bus_command_strobe), .drive_cond(drive_cond),
   .drive_cmd(drive_cmd), .trip_reset_pulse(trip_reset_pulse),
   .drive_state_word(drive_state_word));
`default_nettype wire

/* File: drive_word_pkg.sv */
// How it works
// - Command bits 1:0 pick one of four preset references.
// - Bit 2 low demands DC braking and stop, high allows ramping.
// - Bit 3 low disables the output stage at once so the motor coasts.
// - Bit 4 low demands a quick stop over the quick-stop ramp.
// - Bit 5 low freezes output frequency; only coast or brake stop it.
// - Bit 6 low ramps to stop; high permits a start.
// - A trip clears only on a rising edge of bit 7.
// - Bit 8 high replaces the reference with the jog speed.
// - Bit 9 selects ramp pair one or two.
// - Bit 10 low makes the whole command word ignored.
// - Bits 11 and 12 drive relays only when their function selects them.
// - Bit 13 selects set-up one or two only in multi set-up mode.
// - Bit 15 reverses only when reversing source is bus, OR or AND.
// - Status 0 is control ready, low on trip; status 1 drive ready.
// - Status 2 is low while coasting, high when a start would run.
// - Status 3 trip, 4 error without trip, 6 locked trip.
// - Status 5 is always zero.
// - Status 7 shows any warning.
// - Status 8 high when speed equals reference.
// - Status 9 high under bus control, low on off key or local site.
// - Status 10 frequency inside limits; 11 start present without coast, or running.
// - Status 12 overtemp stop, 13 voltage, 14 torque, 15 thermal timer.
package drive_word_pkg;

   localparam int CMD_REF_LSB = 0;
   localparam int CMD_REF_MSB = 1;
   localparam int CMD_RAMP_NOT_BRAKE = 2;
   localparam int CMD_NO_COAST = 3;
   localparam int CMD_NO_QSTOP = 4;
   localparam int CMD_NO_HOLD = 5;
   localparam int CMD_START = 6;
   localparam int CMD_RESET = 7;
   localparam int CMD_JOG = 8;
   localparam int CMD_RAMP2 = 9;
   localparam int CMD_VALID = 10;
   localparam int CMD_RELAY1 = 11;
   localparam int CMD_RELAY2 = 12;
   localparam int CMD_SETUP = 13;
   localparam int CMD_REVERSE = 15;

   localparam logic [15:0] CMD_RESET_VAL = 16'h0000;

   localparam logic [7:0] RELAY1_SEL_CODE = 8'h24;
   localparam logic [7:0] RELAY2_SEL_CODE = 8'h25;

   // Reversing source selection codes.
   localparam logic [1:0] REV_SRC_INPUT = 2'h0;
   localparam logic [1:0] REV_SRC_BUS = 2'h1;
   localparam logic [1:0] REV_SRC_OR = 2'h2;
   localparam logic [1:0] REV_SRC_AND = 2'h3;

   typedef struct packed {
      logic control_ready;
      logic drive_ready;
      logic tripped;
      logic error_no_trip;
      logic trip_locked;
      logic warning;
      logic speed_at_ref;
      logic off_key;
      logic local_site;
      logic freq_in_limits;
      logic output_running;
      logic overtemp_stop;
      logic voltage_fault;
      logic torque_exceeded;
      logic timer_exceeded;
   } drive_cond_type;

   typedef struct packed {
      logic [7:0] relay1_func;
      logic [7:0] relay2_func;
      logic multi_setup;
      logic [1:0] reverse_src;
   } drive_cfg_type;

   typedef struct packed {
      logic [1:0] preset_sel;
      logic dc_brake;
      logic coast;
      logic quick_stop;
      logic freeze;
      logic ramp_stop;
      logic jog;
      logic ramp_pair2;
      logic relay1;
      logic relay2;
      logic setup2;
      logic reverse;
   } drive_cmd_type;

endpackage : drive_word_pkg
